// ### issi_top.sv
// Overview of operation
// - Eight-bit unit select register loaded from bus drives decoder of many lines.
// - One code may raise several lines; one line may answer several codes.
// - Tape unit 2 record code raises exactly six defined select lines.
// - Select register contents can be read back; decoder outputs are not.
// - Transfer buffer holds program word for recorder, reader word for program.
// - Buffer shifts to pack or split 4-bit tape characters in 16-bit words.
// - Transfer buffer contents can be driven onto the check bus.
// - Select decode presets synchronizer, interlock and control counter per unit.
// - Scope units feed no pulses into the synchronizer.
// - An external pulse sets the first synchronizer stage unless a scope unit is selected.
// - Next carry while first stage set sets the second stage.
// - Next phase pulse gives scope sync, then synchronized pulse clears both stages.
// - Carry source may be swapped for phase pulses to cut jitter.
// - Alarm pulses enter synchronizer and go straight to alarm control.
// - Interlock set by read, record and process-needing select; completion clears.
// - Read or record sense with interlock set gives a stop-clock pulse.
// - Select sense passes for a recorder selection, blocked for a reader.
// - Stop-clock clears interlock so completion later restarts the clock.
// - Each cycle pulse yields four shift pulses, four places per cycle.
// - Completion clears interlock, restarts clock, sets alarm, informs units.
`timescale 1ns/1ps
module issi_top
    import issi_pkg::*;
#(
    parameter int DEPTH = FIFO_DEP
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Computer bus and orders
    input  wire logic [WORD_W-1:0] bus_i,
    input  wire logic              sel_load_i,
    input  wire logic              need_process_i,
    input  wire logic              order_read_i,
    input  wire logic              order_record_i,
    input  wire logic              sel_check_i,
    input  wire logic              buf_check_i,
    // Program word stream into the transfer buffer
    input  wire logic              wr_valid_i,
    output logic                   wr_ready_o,
    input  wire logic              rd_take_i,
    // Control counter and timing pulses
    input  wire logic              cycle_pulse_i,
    input  wire logic              complete_i,
    input  wire logic              restorer_cycle_carry_i,
    input  wire logic              clock_phase_pulse_i,
    input  wire logic              phase_sub_i,
    // External units
    input  wire logic              ext_pulse_i,
    input  wire logic              alarm_pulse_i,
    input  wire logic [CHAR_W-1:0] char_in_i,
    // Selection outputs
    output logic [NSEL-1:0]        sel_lines_o,
    output logic [WORD_W-1:0]      check_o,
    output logic                   preset_o,
    output logic [1:0]             ctrl_preset_o,
    // Transfer buffer outputs
    output logic [WORD_W-1:0]      buf_word_o,
    output logic                   buf_valid_o,
    output logic [CHAR_W-1:0]      char_out_o,
    output logic                   shift_o,
    // Synchronizer outputs
    output logic                   scope_sync_o,
    output logic                   sync_pulse_o,
    output logic                   alarm_direct_o,
    // Interlock outputs
    output logic                   interlock_o,
    output logic                   stop_clock_o,
    output logic                   clock_stopped_o,
    output logic                   restart_o,
    output logic                   alarm_set_o,
    output logic                   ext_complete_o
);
    initial begin
        if (DEPTH < 2) begin
            $error("issi_top: buffer depth too small");
        end
    end

    // Select decoder: classes and modes map onto overlapping lines
    function automatic logic [NSEL-1:0] sel_decode(input logic [SEL_W-1:0] c);
        logic [NSEL-1:0] l;
        logic [2:0]      cls;
        logic [2:0]      md;
        l   = '0;
        cls = c[CLS_MSB:CLS_LSB];
        md  = c[MODE_MSB:MODE_LSB];
        unique case (cls)
            CLS_TAPE: begin
                l[L_UNIT0 + int'(c[UNIT_MSB:UNIT_LSB])] = 1'b1;
                l[L_ALL_TAPE] = 1'b1;
                if (md == MODE_REC) begin
                    l[L_ALL_TAPE_REC] = 1'b1;
                    l[L_ALL_OUTPUT]   = 1'b1;
                    l[L_RD_CAM_NRR]   = 1'b1;
                    l[L_TAPE_REC_NRR] = 1'b1;
                end else if (md == MODE_REREC) begin
                    l[L_ALL_TAPE_REC] = 1'b1;
                    l[L_ALL_OUTPUT]   = 1'b1;
                    l[L_TAPE_REREC]   = 1'b1;
                end else if (md == MODE_RDFWD || md == MODE_RDREV) begin
                    l[L_ALL_READERS]  = 1'b1;
                    l[L_RD_CAM_NRR]   = 1'b1;
                    l[L_TAPE_READ]    = 1'b1;
                end else if (md == MODE_REWIND) begin
                    l[L_RD_CAM_NRR]   = 1'b1;
                end else begin
                    l = '0;
                end
            end
            CLS_SCOPE: begin
                l[L_SCOPE]      = 1'b1;
                l[L_ALL_OUTPUT] = 1'b1;
            end
            CLS_CAMERA: begin
                l[L_CAMERA]     = 1'b1;
                l[L_RD_CAM_NRR] = 1'b1;
                l[L_ALL_OUTPUT] = 1'b1;
            end
            CLS_PUNCH: begin
                l[L_PUNCH]      = 1'b1;
                l[L_ALL_OUTPUT] = 1'b1;
            end
            CLS_PREAD: begin
                l[L_PREAD]       = 1'b1;
                l[L_ALL_READERS] = 1'b1;
                l[L_RD_CAM_NRR]  = 1'b1;
            end
            default: l = '0;
        endcase
        return l;
    endfunction

    logic [SEL_W-1:0]  code_q;
    logic [WORD_W-1:0] buf_q;
    logic [CHAR_W-1:0] char_hold_q;
    logic [2:0]        shift_cnt_q;
    logic [2:0]        shift_cnt_d;
    issi_sync_t        st_q;
    issi_sync_t        st_d;

    // Decode of incoming code and of current selection
    logic [NSEL-1:0] dec_w;
    logic            rec_sel;
    logic            rdr_sel;
    logic            scope_sel;
    logic            proc_w;
    logic [1:0]      preset_w;
    assign dec_w     = sel_decode(bus_i[SEL_W-1:0]);
    assign rec_sel   = sel_lines_o[L_ALL_OUTPUT];
    assign rdr_sel   = sel_lines_o[L_ALL_READERS];
    assign scope_sel = sel_lines_o[L_SCOPE];
    assign proc_w    = dec_w[L_TAPE_READ] | dec_w[L_TAPE_REC_NRR];
    assign preset_w  = dec_w[L_TAPE_READ]    ? PRESET_READ :
                       dec_w[L_TAPE_REC_NRR] ? PRESET_REC  : PRESET_ONE;

    // Select register, decoded lines and reset-control preset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_q        <= '0;
            sel_lines_o   <= '0;
            preset_o      <= 1'b0;
            ctrl_preset_o <= PRESET_ONE;
        end else begin
            preset_o <= sel_load_i;
            if (sel_load_i) begin
                code_q        <= bus_i[SEL_W-1:0];
                sel_lines_o   <= dec_w;
                ctrl_preset_o <= preset_w;
            end
        end
    end

    // Check bus: buffer word or select register read-back
    logic [WORD_W-1:0] check_d;
    assign check_d = buf_check_i ? buf_q :
                     sel_check_i ? {{(WORD_W-SEL_W){1'b0}}, code_q}
                                 : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            check_o <= '0;
        end else begin
            check_o <= check_d;
        end
    end

    // Word FIFO from program into the transfer buffer
    logic              ff_valid;
    logic [WORD_W-1:0] ff_data;
    logic              load_buf;
    issi_fifo #(
        .W (WORD_W),
        .D (DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (wr_valid_i),
        .in_data_i   (bus_i),
        .in_ready_o  (wr_ready_o),
        .out_valid_o (ff_valid),
        .out_data_o  (ff_data),
        .out_ready_i (load_buf)
    );

    // Buffer loads only when empty and not facing a reader
    logic shifting;
    logic shift_in;
    assign load_buf    = ff_valid & ~buf_valid_o & ~rdr_sel;
    assign buf_word_o  = buf_q;
    assign shifting    = shift_cnt_q != '0;
    assign shift_in    = rdr_sel & char_hold_q[CHAR_W-1];
    assign shift_cnt_d = cycle_pulse_i ? SHIFTS :
                         shifting ? shift_cnt_q - 3'h1 : shift_cnt_q;

    // Transfer buffer: load, serial shift by one place per pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_q <= '0;
        end else if (load_buf) begin
            buf_q <= ff_data;
        end else if (shifting) begin
            buf_q <= {buf_q[WORD_W-2:0], shift_in};
        end
    end

    // Character capture and shift pulse count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            char_hold_q <= '0;
            char_out_o  <= '0;
            shift_cnt_q <= '0;
            shift_o     <= 1'b0;
        end else begin
            shift_cnt_q <= shift_cnt_d;
            shift_o     <= shift_cnt_d != '0;
            if (cycle_pulse_i) begin
                char_hold_q <= char_in_i;
                char_out_o  <= buf_q[WORD_W-1:WORD_W-CHAR_W];
            end else if (shifting) begin
                char_hold_q <= {char_hold_q[CHAR_W-2:0], 1'b0};
            end
        end
    end

    // Buffer full flag: set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_valid_o <= 1'b0;
        end else if (load_buf || (complete_i && rdr_sel)) begin
            buf_valid_o <= 1'b1;
        end else if (rd_take_i || (complete_i && rec_sel)) begin
            buf_valid_o <= 1'b0;
        end
    end

    // Synchronizer stages
    logic ext_any;
    logic carry;
    assign ext_any = (ext_pulse_i | alarm_pulse_i) & ~scope_sel;
    assign carry   = phase_sub_i ? clock_phase_pulse_i
                                 : restorer_cycle_carry_i;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            S_IDLE:  if (ext_any) st_d = S_ARMED;
            S_ARMED: if (carry) st_d = S_GATED;
            S_GATED: if (clock_phase_pulse_i) st_d = S_FIRE;
            S_FIRE:  st_d = S_IDLE;
        endcase
        if (sel_load_i) begin
            st_d = S_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q           <= S_IDLE;
            scope_sync_o   <= 1'b0;
            sync_pulse_o   <= 1'b0;
            alarm_direct_o <= 1'b0;
        end else begin
            st_q           <= st_d;
            scope_sync_o   <= st_d == S_FIRE && st_q == S_GATED;
            sync_pulse_o   <= st_q == S_FIRE && !sel_load_i;
            alarm_direct_o <= alarm_pulse_i;
        end
    end

    // Interlock sensing and stop-clock
    logic sense;
    logic stop;
    logic set_il;
    assign sense  = order_read_i | order_record_i
                  | (sel_load_i & rec_sel & ~rdr_sel);
    assign stop   = sense & interlock_o;
    assign set_il = order_read_i | order_record_i
                  | (sel_load_i & (need_process_i | proc_w));

    // Interlock, clock state and completion fan-out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            interlock_o     <= 1'b0;
            stop_clock_o    <= 1'b0;
            clock_stopped_o <= 1'b0;
            restart_o       <= 1'b0;
            alarm_set_o     <= 1'b0;
            ext_complete_o  <= 1'b0;
        end else begin
            stop_clock_o   <= stop;
            restart_o      <= complete_i & clock_stopped_o;
            alarm_set_o    <= complete_i;
            ext_complete_o <= complete_i;
            if (stop) begin
                interlock_o <= 1'b0;
            end else if (set_il) begin
                interlock_o <= 1'b1;
            end else if (complete_i) begin
                interlock_o <= 1'b0;
            end
            if (stop) begin
                clock_stopped_o <= 1'b1;
            end else if (complete_i) begin
                clock_stopped_o <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_fire;
        scope_sync_o ##1 (sync_pulse_o && st_q == S_IDLE);
    endsequence
    sequence seq_done;
        !sync_pulse_o && !scope_sync_o;
    endsequence

    a_stop_on_sense: assert property ((order_read_i || order_record_i)
        && interlock_o |=> stop_clock_o && clock_stopped_o)
        else $error("sense with interlock set did not stop clock");
    a_stop_clears: assert property (stop_clock_o |-> !interlock_o)
        else $error("stop-clock left interlock set");
    a_sel_reader: assert property (sel_load_i && rdr_sel
        && !order_read_i && !order_record_i |=> !stop_clock_o)
        else $error("select after reader stalled");
    a_restart_clk: assert property (complete_i && clock_stopped_o
        && !stop |=> restart_o && !clock_stopped_o && alarm_set_o)
        else $error("completion did not restart clock");
    a_order_sets: assert property (order_record_i && !stop
        |=> interlock_o)
        else $error("record order did not set interlock");
    a_first_stage: assert property (st_q == S_IDLE && ext_pulse_i
        && !scope_sel && !sel_load_i |=> st_q == S_ARMED)
        else $error("external pulse not caught");
    a_second_stage: assert property (st_q == S_ARMED && carry
        && !sel_load_i |=> st_q == S_GATED)
        else $error("carry did not set second stage");
    a_sync_seq: assert property (st_q == S_GATED
        && clock_phase_pulse_i && !sel_load_i ##1 !sel_load_i
        |-> seq_fire ##1 seq_done)
        else $error("synchronized pulse sequence wrong");
    a_shift_four: assert property (cycle_pulse_i
        |=> shift_o [*4])
        else $error("cycle pulse gave fewer than four shifts");
    a_tape2_six: assert property (sel_load_i
        && bus_i[SEL_W-1:0] == CODE_TAPE2_REC
        |=> $countones(sel_lines_o) == 6 && sel_lines_o[L_UNIT0 + 2])
        else $error("tape 2 record code wrong line set");
endmodule

// ### issi_pkg.sv
package issi_pkg;
    // Widths
    localparam int SEL_W    = 8;
    localparam int WORD_W   = 16;
    localparam int CHAR_W   = 4;
    localparam int NSEL     = 16;
    localparam int FIFO_DEP = 8;

    // Select code fields: class, mode, unit
    localparam int CLS_MSB  = 7;
    localparam int CLS_LSB  = 5;
    localparam int MODE_MSB = 4;
    localparam int MODE_LSB = 2;
    localparam int UNIT_MSB = 1;
    localparam int UNIT_LSB = 0;

    // Unit classes
    localparam logic [2:0] CLS_TAPE   = 3'h1;
    localparam logic [2:0] CLS_SCOPE  = 3'h2;
    localparam logic [2:0] CLS_CAMERA = 3'h3;
    localparam logic [2:0] CLS_PUNCH  = 3'h4;
    localparam logic [2:0] CLS_PREAD  = 3'h5;

    // Tape modes
    localparam logic [2:0] MODE_REC    = 3'h0;
    localparam logic [2:0] MODE_REREC  = 3'h1;
    localparam logic [2:0] MODE_RDFWD  = 3'h2;
    localparam logic [2:0] MODE_RDREV  = 3'h3;
    localparam logic [2:0] MODE_REWIND = 3'h4;

    // Code for recording on tape unit 2
    localparam logic [7:0] CODE_TAPE2_REC = 8'h22;

    // Select line positions
    localparam int L_UNIT0        = 0;
    localparam int L_ALL_TAPE_REC = 4;
    localparam int L_ALL_OUTPUT   = 5;
    localparam int L_RD_CAM_NRR   = 6;
    localparam int L_TAPE_REC_NRR = 7;
    localparam int L_ALL_TAPE     = 8;
    localparam int L_ALL_READERS  = 9;
    localparam int L_TAPE_REREC   = 10;
    localparam int L_TAPE_READ    = 11;
    localparam int L_SCOPE        = 12;
    localparam int L_CAMERA       = 13;
    localparam int L_PUNCH        = 14;
    localparam int L_PREAD        = 15;

    // Control counter presets
    localparam logic [1:0] PRESET_READ = 2'h0;
    localparam logic [1:0] PRESET_REC  = 2'h2;
    localparam logic [1:0] PRESET_ONE  = 2'h3;

    // Shift pulses per cycle pulse
    localparam logic [2:0] SHIFTS = 3'h4;

    // Timing
    localparam int CLK_MHZ        = 100;
    localparam int JITTER_MAX_US  = 30;
    localparam int JITTER_MAX_CYC = JITTER_MAX_US * CLK_MHZ;

    // Synchronizer stages
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_ARMED = 2'b01,
        S_GATED = 2'b10,
        S_FIRE  = 2'b11
    } issi_sync_t;
endpackage

// ### issi_fifo.sv
`timescale 1ns/1ps
module issi_fifo
    import issi_pkg::*;
#(
    parameter int W = 16,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // Drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    initial begin
        if (D < 2 || (D & (D - 1)) != 0 || W < 1) begin
            $error("issi_fifo: depth must be a power of two");
        end
    end

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    // Handshakes and occupancy
    assign push  = in_valid_i & in_ready_o;
    assign pop   = out_valid_o & out_ready_i;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    // Pointers, count and registered flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q        <= '0;
            rp_q        <= '0;
            cnt_q       <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            wp_q        <= wp_q + AW'(push);
            rp_q        <= rp_q + AW'(pop);
            cnt_q       <= cnt_d;
            in_ready_o  <= cnt_d != (AW+1)'(D);
            out_valid_o <= cnt_d != '0;
        end
    end

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    // Read data registered, head word after each move
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_data_o <= '0;
        end else if (push && (cnt_q == '0 || (pop && cnt_q == 1))) begin
            out_data_o <= in_data_i;
        end else if (pop) begin
            out_data_o <= mem_q[rp_q + AW'(1)];
        end
    end
endmodule

// ### issi_eu_model.sv
`timescale 1ns/1ps
module issi_eu_model #(
    parameter int LAT = 3
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Request from bench and unit outputs
    input  wire logic       req_i,
    output logic            ext_pulse_o,
    output logic [3:0]      char_o
);
    int   cnt;
    logic req_seen;
    // Unit pulses once when ready, LAT cycles after the request
    initial begin
        ext_pulse_o = 1'b0;
        char_o      = 4'h0;
        cnt         = 0;
        req_seen    = 1'b0;
        forever begin
            @(posedge clk_i);
            req_seen = req_i && !rst_i; // Request as seen at the edge
            #1;
            char_o      <= char_o + 4'h5; // Undriven data keeps moving
            ext_pulse_o <= (cnt == 1) && !rst_i;
            if (req_seen && cnt == 0) begin
                cnt = LAT;
            end else if (cnt > 0) begin
                cnt = cnt - 1;
            end
        end
    end
endmodule

// ### test_io_select_sync_interlock.sv
`timescale 1ns/1ps
module test_io_select_sync_interlock;
    import issi_pkg::*;
    logic clk_i = 0, rst_i = 1, sel_load_i = 0, need_process_i = 0;
    logic order_read_i = 0, order_record_i = 0, sel_check_i = 0;
    logic buf_check_i = 0, wr_valid_i = 0, rd_take_i = 0;
    logic cycle_pulse_i = 0, complete_i = 0, carry_i = 0, phase_i = 0;
    logic alarm_pulse_i = 0, eu_req = 0, phase_sub_i = 0, ext_pulse_i;
    logic [WORD_W-1:0] bus_i = '0;
    logic [CHAR_W-1:0] char_in_i;
    logic wr_ready_o, buf_valid_o, shift_o, scope_sync_o, sync_pulse_o;
    logic alarm_direct_o, interlock_o, stop_clock_o, clock_stopped_o;
    logic restart_o, alarm_set_o, ext_complete_o, preset_o;
    logic [NSEL-1:0]   sel_lines_o;
    logic [WORD_W-1:0] check_o, buf_word_o;
    logic [1:0]        ctrl_preset_o;
    logic [CHAR_W-1:0] char_out_o;
    int bad_count = 0, checks_done = 0, n;

    issi_top issi_top_i (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
        .sel_load_i(sel_load_i), .need_process_i(need_process_i),
        .order_read_i(order_read_i), .order_record_i(order_record_i),
        .sel_check_i(sel_check_i), .buf_check_i(buf_check_i),
        .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
        .rd_take_i(rd_take_i), .cycle_pulse_i(cycle_pulse_i),
        .complete_i(complete_i), .restorer_cycle_carry_i(carry_i),
        .clock_phase_pulse_i(phase_i), .phase_sub_i(phase_sub_i),
        .ext_pulse_i(ext_pulse_i), .alarm_pulse_i(alarm_pulse_i),
        .char_in_i(char_in_i), .sel_lines_o(sel_lines_o),
        .check_o(check_o), .preset_o(preset_o),
        .ctrl_preset_o(ctrl_preset_o), .buf_word_o(buf_word_o),
        .buf_valid_o(buf_valid_o), .char_out_o(char_out_o),
        .shift_o(shift_o), .scope_sync_o(scope_sync_o),
        .sync_pulse_o(sync_pulse_o), .alarm_direct_o(alarm_direct_o),
        .interlock_o(interlock_o), .stop_clock_o(stop_clock_o),
        .clock_stopped_o(clock_stopped_o), .restart_o(restart_o),
        .alarm_set_o(alarm_set_o), .ext_complete_o(ext_complete_o));
    issi_eu_model issi_eu_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(eu_req), .ext_pulse_o(ext_pulse_i), .char_o(char_in_i));

    // Clock at 100 MHz
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task close_out;
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task step;
        @(posedge clk_i);
        #1;
    endtask
    task sel(input logic [7:0] code, input logic np);
        bus_i = {8'h00, code};
        sel_load_i = 1;
        need_process_i = np;
        step;
        sel_load_i = 0;
    endtask
    task complete;
        complete_i = 1;
        step;
        complete_i = 0;
    endtask

    // Tape 2 record code, read-back and presets
    task t_select;
        sel(CODE_TAPE2_REC, 1'b1);
        chk("sel_lines", 16'h01f4, sel_lines_o);
        chk("preset", 16'h0001, {15'h0, preset_o});
        chk("ctrl_preset", 16'h0002, {14'h0, ctrl_preset_o});
        chk("il_select", 16'h0001, {15'h0, interlock_o});
        sel_check_i = 1;
        step;
        sel_check_i = 0;
        chk("readback", 16'h0022, check_o);
        complete;
        chk("il_cleared", 16'h0000, {15'h0, interlock_o});
    endtask
    // Record then read: stall and restart
    task t_interlock;
        order_record_i = 1;
        step;
        order_record_i = 0;
        chk("il_record", 16'h0001, {15'h0, interlock_o});
        order_read_i = 1;
        step;
        order_read_i = 0;
        chk("stop", 16'h0003, {14'h0, stop_clock_o, clock_stopped_o});
        chk("il_stop", 16'h0000, {15'h0, interlock_o});
        complete;
        chk("restart", 16'h000e, {12'h0, restart_o, alarm_set_o,
            ext_complete_o, clock_stopped_o});
    endtask
    // Select after a reader selection is not stalled
    task t_reader_select;
        sel(8'h28, 1'b1);
        step;
        sel(CODE_TAPE2_REC, 1'b0);
        chk("no_stop", 16'h0000, {15'h0, stop_clock_o});
        complete;
    endtask
    // Synchronizer stages and pulse width
    task t_sync;
        eu_req = 1;
        step;
        eu_req = 0;
        n = 0;
        while (ext_pulse_i !== 1'b1 && n < 20) begin
            step;
            n++;
        end
        step;
        phase_i = 1;
        step;
        phase_i = 0;
        chk("no_carry", 16'h0000, {15'h0, scope_sync_o});
        carry_i = 1;
        step;
        carry_i = 0;
        phase_i = 1;
        step;
        phase_i = 0;
        chk("scope_sync", 16'h0001, {15'h0, scope_sync_o});
        step;
        chk("sync_pulse", 16'h0001, {15'h0, sync_pulse_o});
        step;
        chk("sync_width", 16'h0000, {15'h0, sync_pulse_o});
        alarm_pulse_i = 1;
        step;
        alarm_pulse_i = 0;
        chk("alarm_direct", 16'h0001, {15'h0, alarm_direct_o});
        phase_sub_i = 1;
        phase_i = 1;
        repeat (2) step;
        phase_i = 0;
        phase_sub_i = 0;
        chk("phase_carry", 16'h0001, {15'h0, scope_sync_o});
        sel(CODE_TAPE2_REC, 1'b0);
    endtask
    // Fill the FIFO, shift the buffer, then drain
    task t_buffer;
        n = 0;
        wr_valid_i = 1;
        repeat (20) begin
            bus_i = 16'ha5c3 + n[15:0];
            if (wr_ready_o === 1'b1) n++;
            step;
        end
        wr_valid_i = 0;
        chk("refused", 16'h0000, {15'h0, wr_ready_o});
        chk("filled", 16'(FIFO_DEP + 1), n[15:0]);
        buf_check_i = 1;
        step;
        chk("buf_word", 16'ha5c3, check_o);
        cycle_pulse_i = 1;
        step;
        cycle_pulse_i = 0;
        chk("char_out", 16'h000a, {12'h0, char_out_o});
        repeat (4) begin
            chk("shifting", 16'h0001, {15'h0, shift_o});
            step;
        end
        chk("shift_end", 16'h0000, {15'h0, shift_o});
        chk("buf_shifted", 16'h5c30, buf_word_o);
        step;
        chk("shifted", 16'h05c3, {4'h0, check_o[15:4]});
        buf_check_i = 0;
        repeat (12) begin
            complete;
            rd_take_i = 1;
            step;
            rd_take_i = 0;
            repeat (3) step; // Orders spaced by the transfer time
        end
        chk("drained", 16'h0001, {15'h0, wr_ready_o});
        chk("last_word", 16'ha5cb, buf_word_o);
        chk("buf_empty", 16'h0000, {15'h0, buf_valid_o});
    endtask

    // Watchdog
    initial begin
        #100000;
        bad_count++;
        close_out();
    end
    // Main sequence
    initial begin
        repeat (8) step;
        rst_i = 0;
        chk("rst_ready", 16'h0001, {15'h0, wr_ready_o});
        t_select();
        t_interlock();
        t_reader_select();
        t_sync();
        t_buffer();
        close_out();
    end
endmodule
